// File: core/adsc_cfg.svh
// Constants for the converter serial control port
`ifndef ADSC_CFG_SVH
`define ADSC_CFG_SVH
`define ADSC_CFG_W 12
`define ADSC_FRAME_LEN 16
`define ADSC_CAPTURE_LEN 12
`define ADSC_MUX_EDGE 14
`define ADSC_CNT_W 5
`define ADSC_BIT_WRITE 11
`define ADSC_BIT_SEQUENCE 10
`define ADSC_CH_HI 8
`define ADSC_CH_LO 6
`define ADSC_PM_HI 5
`define ADSC_PM_LO 4
`define ADSC_BIT_SHADOW 3
`define ADSC_BIT_RANGE 1
`define ADSC_BIT_CODING 0
`define ADSC_CFG_RESET 12'hff3
`define ADSC_PM_NORMAL 2'h3
`define ADSC_PM_FULL_SD 2'h2
`define ADSC_PM_AUTO_SD 2'h1
`define ADSC_PM_INVALID 2'h0
`endif

// File: core/adsc_pkg.sv
// Types for the converter serial control port
package adsc_pkg;
  typedef enum logic [1:0] {
    ADSC_PM_INVALID_E = 2'h0,
    ADSC_PM_AUTO_E = 2'h1,
    ADSC_PM_FULL_E = 2'h2,
    ADSC_PM_NORMAL_E = 2'h3
  } adsc_pm_t;

  typedef struct packed {
    logic sequence_enable_bit;
    logic channel_mask_select;
    logic [2:0] channel_address;
    adsc_pm_t power_mode;
    logic range_single;
    logic coding_binary;
  } adsc_ctrl_t;

  typedef struct packed {
    logic [2:0] channel;
    logic [11:0] data;
  } adsc_result_t;
endpackage : adsc_pkg

// File: core/adsc_port.sv
// Serial control and result port of an eight channel converter
`timescale 1ns/1ps
`default_nettype none
`include "adsc_cfg.svh"
module adsc_port #(
  parameter int DATA_W = 12
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_clk_i,
  input wire logic serial_config_in_i,
  input wire logic [DATA_W-1:0] conv_data_i,
  output logic serial_result_out_o,
  output logic serial_result_oe_o,
  output logic conv_start_o,
  output logic [2:0] mux_channel_o,
  output adsc_pkg::adsc_ctrl_t active_ctrl_o,
  output logic full_shutdown_o,
  output logic auto_shutdown_o,
  output logic invalid_power_o
);
  // Wider data would not fit the fixed sixteen bit frame
  if (DATA_W < 1 || DATA_W > `ADSC_CAPTURE_LEN) begin : g_bad_width
    $error("DATA_W out of range");
  end
  if ((1 << `ADSC_CNT_W) <= `ADSC_FRAME_LEN) begin : g_bad_cnt
    $error("edge counter too narrow");
  end

  // Two stage synchronisers; first stage read only by the second
  // Reset to the idle levels so no edge is seen right after reset
  logic [1:0] cs_sync_q;
  logic [1:0] sck_sync_q;
  logic [1:0] din_sync_q;
  logic cs_prev_q;
  logic sck_prev_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync_q <= 2'h3;
      cs_prev_q <= 1'b1;
    end else begin
      cs_sync_q <= {cs_sync_q[0], frame_sel_n_i};
      cs_prev_q <= cs_sync_q[1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_sync_q <= 2'h3;
      sck_prev_q <= 1'b1;
    end else begin
      sck_sync_q <= {sck_sync_q[0], serial_clk_i};
      sck_prev_q <= sck_sync_q[1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      din_sync_q <= 2'h0;
    end else begin
      din_sync_q <= {din_sync_q[0], serial_config_in_i};
    end
  end

  wire logic cs_low = !cs_sync_q[1];
  wire logic cs_fall = cs_prev_q && !cs_sync_q[1];
  wire logic cs_rise = !cs_prev_q && cs_sync_q[1];
  wire logic sck_fall = cs_low && !cs_fall && sck_prev_q && !sck_sync_q[1];

  function automatic adsc_pkg::adsc_ctrl_t decode(input logic [`ADSC_CFG_W-1:0] w);
    adsc_pkg::adsc_ctrl_t c;
    c.sequence_enable_bit = w[`ADSC_BIT_SEQUENCE];
    c.channel_mask_select = w[`ADSC_BIT_SHADOW];
    c.channel_address = w[`ADSC_CH_HI:`ADSC_CH_LO];
    c.power_mode = adsc_pkg::adsc_pm_t'(w[`ADSC_PM_HI:`ADSC_PM_LO]);
    c.range_single = w[`ADSC_BIT_RANGE];
    c.coding_binary = w[`ADSC_BIT_CODING];
    return c;
  endfunction : decode

  // True when the count shows that the next fall is edge number n
  function automatic logic is_edge(input logic [`ADSC_CNT_W-1:0] cnt, input int unsigned n);
    return cnt == `ADSC_CNT_W'(n - 1);
  endfunction : is_edge

  // Power field compare, shared by the three mode flags
  function automatic logic pm_is(input logic [`ADSC_CFG_W-1:0] w, input logic [1:0] code);
    return w[`ADSC_PM_HI:`ADSC_PM_LO] == code;
  endfunction : pm_is

  // Falling edge count within a frame; saturates so extra edges do nothing
  logic [`ADSC_CNT_W-1:0] edge_cnt_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      edge_cnt_q <= '0;
    end else if (cs_fall) begin
      edge_cnt_q <= '0;
    end else if (sck_fall && edge_cnt_q != `ADSC_CNT_W'(`ADSC_FRAME_LEN)) begin
      edge_cnt_q <= edge_cnt_q + `ADSC_CNT_W'(1);
    end
  end

  // Twelfth fall ends the word, fourteenth ends the conversion
  logic capture_on;
  logic word_done;
  logic conv_done;
  assign capture_on = sck_fall && edge_cnt_q < `ADSC_CNT_W'(`ADSC_CAPTURE_LEN);
  assign word_done = sck_fall && is_edge(edge_cnt_q, `ADSC_CAPTURE_LEN);
  assign conv_done = sck_fall && is_edge(edge_cnt_q, `ADSC_MUX_EDGE);

  // Shift register for the incoming word
  logic [`ADSC_CFG_W-1:0] shift_q;
  logic [`ADSC_CFG_W-1:0] word_in;
  assign word_in = {shift_q[`ADSC_CFG_W-2:0], din_sync_q[1]};
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
    end else if (capture_on) begin
      shift_q <= word_in;
    end
  end

  // Staged word; a cut frame drops it, so a later frame cannot replay it
  logic [`ADSC_CFG_W-1:0] pending_q;
  logic pending_vld_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pending_q <= `ADSC_CFG_RESET;
      pending_vld_q <= 1'b0;
    end else if (cs_fall || conv_done) begin
      pending_vld_q <= 1'b0;
    end else if (word_done && word_in[`ADSC_BIT_WRITE]) begin
      pending_q <= word_in;
      pending_vld_q <= 1'b1;
    end
  end

  // Write-only stored word with no read path; loaded as the conversion ends
  logic [`ADSC_CFG_W-1:0] cfg_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= `ADSC_CFG_RESET;
    end else if (conv_done && pending_vld_q) begin
      cfg_q <= pending_q;
    end
  end

  // Mux channel for the next conversion
  logic [2:0] mux_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mux_q <= '0;
    end else if (conv_done) begin
      mux_q <= pending_vld_q ? pending_q[`ADSC_CH_HI:`ADSC_CH_LO]
                             : cfg_q[`ADSC_CH_HI:`ADSC_CH_LO];
    end
  end

  // Narrow data is left aligned; the trailing bits are the zero pad
  logic [`ADSC_CAPTURE_LEN-1:0] data_pad;
  assign data_pad = `ADSC_CAPTURE_LEN'(conv_data_i) << (`ADSC_CAPTURE_LEN - DATA_W);

  // Result frame captured at select fall; tag is mux_q, the channel of the conversion this select fall starts
  logic [`ADSC_FRAME_LEN-1:0] out_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_q <= '0;
    end else if (cs_fall) begin
      out_q <= {1'b0, mux_q, data_pad};
    end else if (sck_fall) begin
      out_q <= {out_q[`ADSC_FRAME_LEN-2:0], 1'b0};
    end
  end

  // Enable follows the synchronised select, so it drops three clocks late
  logic oe_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      oe_q <= 1'b0;
    end else if (cs_fall) begin
      oe_q <= 1'b1;
    end else if (cs_rise) begin
      oe_q <= 1'b0;
    end
  end

  logic start_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= cs_fall;
    end
  end

  assign serial_result_out_o = out_q[`ADSC_FRAME_LEN-1] & oe_q;
  assign serial_result_oe_o = oe_q;
  assign conv_start_o = start_q;
  assign mux_channel_o = mux_q;
  assign active_ctrl_o = decode(cfg_q);
  assign full_shutdown_o = pm_is(cfg_q, `ADSC_PM_FULL_SD);
  assign auto_shutdown_o = pm_is(cfg_q, `ADSC_PM_AUTO_SD);
  assign invalid_power_o = pm_is(cfg_q, `ADSC_PM_INVALID);
endmodule : adsc_port
`default_nettype wire

// File: sim/adsc_host.sv
// Host serial master model
`timescale 1ns/1ps
`default_nettype none
module adsc_host (
  input wire logic ref_clk_i,
  input wire logic serial_result_i,
  output logic frame_sel_n_o,
  output logic serial_clk_o,
  output logic serial_config_o
);
  initial begin
    frame_sel_n_o = 1'b1;
    serial_clk_o = 1'b1;
    serial_config_o = 1'b0;
  end
  // Clock idles high between frames; 400 ns period
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    @(negedge ref_clk_i);
    frame_sel_n_o = 1'b0;
    repeat (4) @(negedge ref_clk_i);
    for (int i = 15; i >= 0; i--) begin
      serial_config_o = tx[i];
      repeat (4) @(negedge ref_clk_i);
      rx[i] = serial_result_i;
      serial_clk_o = 1'b0;
      repeat (4) @(negedge ref_clk_i);
      serial_clk_o = 1'b1;
    end
    repeat (4) @(negedge ref_clk_i);
    frame_sel_n_o = 1'b1;
    serial_config_o = ~serial_config_o;
    repeat (8) @(negedge ref_clk_i);
  endtask : xfer
endmodule : adsc_host
`default_nettype wire

// File: sim/adsc_port_test.sv
// Self-checking bench for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module adsc_port_test;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [11:0] conv_data_i = 12'h000;
  logic frame_sel_n_i, serial_clk_i, serial_config_in_i, serial_result_out_o;
  logic serial_result_oe_o, conv_start_o, full_shutdown_o, auto_shutdown_o, invalid_power_o;
  logic [2:0] mux_channel_o;
  adsc_pkg::adsc_ctrl_t active_ctrl_o;
  int miscompares = 0;
  int n_compared = 0;
  logic [15:0] rx;
  logic [8:0] exp_ctrl = 9'h17f;
  logic [2:0] exp_ch = 3'h0;
  logic [1:0] pm;
  // Pad nibble varies to show late bits are ignored
  logic [15:0] words [5] = '{16'h8e8f, 16'h7fff, 16'hd5b0, 16'h8c2f, 16'hbf30};
  always #25 ref_clk_i = ~ref_clk_i;
  adsc_port adsc_port_i (.*);
  adsc_host adsc_host_i (.ref_clk_i, .serial_result_i(serial_result_out_o),
    .frame_sel_n_o(frame_sel_n_i), .serial_clk_o(serial_clk_i),
    .serial_config_o(serial_config_in_i));
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic chk_state();
    pm = exp_ctrl[3:2];
    cmp({1'b0, active_ctrl_o, mux_channel_o, full_shutdown_o, auto_shutdown_o, invalid_power_o},
      {1'b0, exp_ctrl, exp_ch, pm == 2'h2, pm == 2'h1, pm == 2'h0});
  endtask : chk_state
  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (12) @(negedge ref_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge ref_clk_i);
    chk_state();
    for (int i = 0; i < 5; i++) begin
      conv_data_i = ~words[i][15:4];
      adsc_host_i.xfer(words[i], rx);
      cmp(rx, {1'b0, exp_ch, conv_data_i});
      if (words[i][15]) begin
        exp_ctrl = {words[i][14], words[i][7], words[i][12:8], words[i][5:4]};
        exp_ch = words[i][12:10];
      end
      chk_state();
    end
    tally_and_finish();
  end
endmodule : adsc_port_test
`default_nettype wire

// File: sim/adsc_props.sv
// Checker for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module adsc_props (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic frame_sel_n_i,
  input wire logic serial_result_out_o,
  input wire logic serial_result_oe_o,
  input wire logic conv_start_o,
  input wire logic [2:0] mux_channel_o,
  input wire adsc_pkg::adsc_ctrl_t active_ctrl_o,
  input wire logic full_shutdown_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_out_quiet: assert property (frame_sel_n_i [*4] |-> !serial_result_out_o)
    else $error("result driven while idle");
  // Five cycles cover the pin synchroniser
  chk_oe_drop: assert property (frame_sel_n_i [*5] |-> !serial_result_oe_o)
    else $error("output enable stuck");
  chk_start_after: assert property ($rose(serial_result_oe_o)
    |-> conv_start_o ##1 !conv_start_o) else $error("no start pulse");
  chk_lead_zero: assert property ($rose(serial_result_oe_o) |-> !serial_result_out_o)
    else $error("leading bit not zero");
  chk_ctrl_hold: assert property (!serial_result_oe_o && !$past(serial_result_oe_o)
    |-> $stable(active_ctrl_o)) else $error("word changed outside frame");
  chk_mux_in_frame: assert property ($changed(mux_channel_o) |-> serial_result_oe_o)
    else $error("mux moved outside frame");
  chk_mux_follows: assert property ($changed(mux_channel_o)
    |-> mux_channel_o == active_ctrl_o.channel_address) else $error("mux differs");
  chk_full_decode: assert property (full_shutdown_o
    == (active_ctrl_o.power_mode == adsc_pkg::ADSC_PM_FULL_E))
    else $error("full shutdown decode");
endmodule : adsc_props
bind adsc_port adsc_props adsc_props_i (.*);
`default_nettype wire
